/* dfd_pkg.sv */
package dfd_pkg;
// ==========================================================
// Overview of operation
// [R1] One phase-error sample is taken per divided reference period.
// [R2] Rate exponent is five bits, clamped 5..16, divide ratio two to it.
// [R3] Loop filter steps once per divider period; interpolator restores full rate.
// [R4] Interpolator is a squared length-P comb-integrator, unity gain at DC.
// [R5] Software places the first null above 80x bandwidth and 1.5x reference.
// [R6] Software keeps the exponent within the null limits, clamped 5..16.
// [R7] Phase accumulator adds the tuning word every cycle, wrapping modulo 2^48.
// [R8] Output frequency is tuning word over 2^48 times sample rate.
// [R9] A 14-bit phase offset is added to the synthesizer phase.
// [R10] Control bit 0 selects closed loop when set, open loop when clear.
// [R11] Single-tone mode uses the stored tone word and ignores references.
// [R12] In single tone the estimator may supply tuning word and phase offset.
// [R13] Single-tone mode is entered only by software, never automatically.
// [R14] Single-tone mode ignores the tuning word least significant bit.
// [R15] Holdover replays words recorded while closed; needs one prior closed run.
// [R16] Holdover entry and exit are automatic or manual per control bits.
// [R17] Closed loop takes the tuning word from the filter output each update.
// [R18] Phase offset has no effect while the loop is closed.
// [R19] Ten-bit DAC current scale code spans the two scale registers.
// [R20] Coarse detector counts sample clocks between reference and feedback edges.
// [R21] Coarse gain is multiplier times two to the shift plus six.
// [R22] Fine result is used when valid, coarse on fine over or underflow.
// [R23] Damping coefficients are programmed positive and applied as negative.
// [R24] Loop gain is mantissa over 2048, left shift 0..22, right shift 0..7.
// [R25] Interpolator gain is normalised by right shifts, not division.
// ==========================================================
// register map
localparam int ADDR_W = 12;
localparam logic [11:0] OFS_CTL = 12'h100;
localparam logic [11:0] OFS_STAT = 12'h101;
localparam logic [11:0] OFS_FSC_LO = 12'h40B;
localparam logic [11:0] OFS_FSC_HI = 12'h40C;
localparam logic [11:0] OFS_CFG = 12'h200;
localparam int CFG_N = 21;
// configuration byte indices
localparam int CI_SINGLE_TONE_TUNING_WORD = 0;
localparam int CI_PHOFS = 6;
localparam int CI_PEXP = 8;
localparam int CI_A0 = 9;
localparam int CI_A1 = 11;
localparam int CI_A2 = 12;
localparam int CI_B0 = 13;
localparam int CI_B1 = 15;
localparam int CI_G0 = 16;
localparam int CI_G1 = 18;
localparam int CI_CSH = 19;
localparam int CI_CMUL = 20;
// control bits
localparam int CTL_CLOSE = 0;
localparam int CTL_EST = 1;
localparam int CTL_AUTO = 2;
localparam int CTL_HOLD = 3;
localparam logic [7:0] CTL_MASK = 8'h0F;
// reset values
localparam logic [7:0] CTL_RST = 8'h00;
localparam logic [7:0] CFG_RST = 8'h00;
localparam logic [9:0] FSC_RST = 10'h1F9;
// widths and limits
localparam int ACC_W = 48;
localparam int PH_W = 14;
localparam int FSC_W = 10;
localparam int ERR_W = 40;
localparam int CP_W = 18;
localparam logic [4:0] PEXP_MIN = 5'h05;
localparam logic [4:0] PEXP_MAX = 5'h10;
localparam logic [4:0] A1_MAX = 5'h16;
localparam int ALPHA_SH = 11;
localparam int COEF_SH = 15;
localparam logic [4:0] CP_GAIN_SH = 5'h06;
// timing
localparam int CLK_PERIOD_NS = 20;
localparam int CP_SPAN_NS = 131000;
typedef enum logic [1:0] {
  MD_TONE = 2'b00,
  MD_LOOP = 2'b01,
  MD_HOLD = 2'b10
} dfd_mode_t;
endpackage

/* dfd_core.sv */
`timescale 1ns/1ps
module dfd_core
  import dfd_pkg::*;
#(
  parameter int FINE_W = 24,
  parameter int CP_SPAN_CYC = (CP_SPAN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // register port
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // phase detector front end
  input wire logic PH_SAMPLE,
  input wire logic signed [FINE_W-1:0] PH_FINE,
  input wire logic PH_FINE_OVF,
  input wire logic REF_EDGE,
  input wire logic FB_EDGE,
  input wire logic REF_LOST,
  // frequency estimator
  input wire logic [ACC_W-1:0] EST_FTW,
  input wire logic [PH_W-1:0] EST_PHASE,
  // synthesizer
  output logic [PH_W-1:0] DDS_PHASE,
  output logic [ACC_W-1:0] FTW_OUT,
  output logic [FSC_W-1:0] DAC_FSC,
  output logic [1:0] MODE,
  output logic HOLD_READY
);

  // ==========================================================
  // helpers
  function automatic logic [4:0] pexp_clamp(input logic [4:0] v);
    if (v < PEXP_MIN) begin
      return PEXP_MIN;
    end
    if (v > PEXP_MAX) begin
      return PEXP_MAX;
    end
    return v;
  endfunction

  // magnitude m * 2^-(s+15) applied to v
  function automatic logic signed [ERR_W-1:0] mag_scale(
    input logic signed [ERR_W-1:0] v,
    input logic [11:0] m,
    input logic [2:0] s
  );
    logic signed [55:0] p;
    p = 56'(v) * $signed({1'b0, m});
    return ERR_W'(p >>> (s + COEF_SH));
  endfunction

  // writable bits of each configuration byte
  function automatic logic [7:0] cfg_mask(input int i);
    case (i)
      CI_PHOFS + 1, CI_CMUL: return 8'h3F;
      CI_PEXP, CI_A1: return 8'h1F;
      CI_A0 + 1, CI_B0 + 1, CI_G0 + 1: return 8'h0F;
      CI_A2, CI_B1, CI_G1, CI_CSH: return 8'h07;
      default: return 8'hFF;
    endcase
  endfunction

  // ==========================================================
  // registers
  logic [7:0] ctl;
  logic [7:0] fsc_lo;
  logic [1:0] fsc_hi;
  logic [7:0] cfg [CFG_N];
  logic hold_ok;
  logic coarse_used;
  dfd_mode_t mode;

  wire cfg_hit = (REG_ADDR >= OFS_CFG) && (REG_ADDR < OFS_CFG + CFG_N);
  wire [4:0] cfg_idx = 5'(REG_ADDR - OFS_CFG);
  wire [7:0] stat = {5'h00, coarse_used, mode == MD_HOLD, hold_ok};

  // writes; status and unmapped addresses drop the data
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ctl <= CTL_RST;
      fsc_lo <= FSC_RST[7:0];
      fsc_hi <= FSC_RST[9:8];
      for (int i = 0; i < CFG_N; i++) begin
        cfg[i] <= CFG_RST;
      end
      cfg[CI_PEXP] <= {3'h0, PEXP_MIN};
    end else if (REG_WR) begin
      if (REG_ADDR == OFS_CTL) begin
        ctl <= REG_WDATA & CTL_MASK;
      end
      if (REG_ADDR == OFS_FSC_LO) begin
        fsc_lo <= REG_WDATA;
      end
      if (REG_ADDR == OFS_FSC_HI) begin
        fsc_hi <= REG_WDATA[1:0];
      end
      if (cfg_hit) begin
        cfg[cfg_idx] <= REG_WDATA & cfg_mask(int'(cfg_idx));
      end
    end
  end

  // read data stand one cycle, zero otherwise
  wire [7:0] rd_mux = (REG_ADDR == OFS_CTL) ? ctl :
                      (REG_ADDR == OFS_STAT) ? stat :
                      (REG_ADDR == OFS_FSC_LO) ? fsc_lo :
                      (REG_ADDR == OFS_FSC_HI) ? {6'h00, fsc_hi} :
                      cfg_hit ? cfg[cfg_idx] : 8'h00;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B || !REG_RD) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rd_mux;
    end
  end

  // field decode
  wire [ACC_W-1:0] tone_ftw = {cfg[5], cfg[4], cfg[3], cfg[2], cfg[1], cfg[0]};
  wire [PH_W-1:0] phofs = {cfg[CI_PHOFS+1][5:0], cfg[CI_PHOFS]};
  wire [4:0] pexp = pexp_clamp(cfg[CI_PEXP][4:0]); // R2
  wire [11:0] a0 = {cfg[CI_A0+1][3:0], cfg[CI_A0]};
  wire [4:0] a1 = (cfg[CI_A1][4:0] > A1_MAX) ? A1_MAX : cfg[CI_A1][4:0];
  wire [2:0] a2 = cfg[CI_A2][2:0];
  wire [11:0] b0 = {cfg[CI_B0+1][3:0], cfg[CI_B0]};
  wire [2:0] b1 = cfg[CI_B1][2:0];
  wire [11:0] g0 = {cfg[CI_G0+1][3:0], cfg[CI_G0]};
  wire [2:0] g1 = cfg[CI_G1][2:0];
  wire [2:0] csh = cfg[CI_CSH][2:0];
  wire [5:0] cmul = cfg[CI_CMUL][5:0];

  // the scale code is held straight in the two registers
  assign DAC_FSC = {fsc_hi, fsc_lo}; // R19

  // ==========================================================
  // loop filter rate divider
  logic [16:0] p_cnt;
  wire [16:0] p_len = 17'h00001 << pexp;
  // >= keeps the period sane if the exponent shrinks mid-count
  wire tick = (p_cnt >= 17'(p_len - 17'h00001)); // R2
  wire [16:0] p_m = 17'(p_cnt + 17'h00001);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B || tick) begin
      p_cnt <= 17'h00000;
    end else begin
      p_cnt <= 17'(p_cnt + 17'h00001);
    end
  end

  // ==========================================================
  // coarse detector: sample clocks between the two edges
  logic cp_run;
  logic cp_neg;
  logic [CP_W-1:0] cp_cnt;
  logic signed [CP_W:0] cp_res;
  wire cp_stop = cp_neg ? REF_EDGE : FB_EDGE;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      cp_run <= 1'b0;
      cp_neg <= 1'b0;
      cp_cnt <= '0;
      cp_res <= '0;
    end else if (!cp_run) begin
      if (REF_EDGE && FB_EDGE) begin
        cp_res <= '0;
      end else if (REF_EDGE || FB_EDGE) begin
        cp_run <= 1'b1;
        cp_neg <= FB_EDGE;
        cp_cnt <= CP_W'(1);
      end
    end else if (cp_stop) begin
      cp_run <= 1'b0;
      cp_res <= cp_neg ? -$signed({1'b0, cp_cnt}) : $signed({1'b0, cp_cnt}); // R20
    end else if (cp_cnt < CP_W'(CP_SPAN_CYC)) begin
      cp_cnt <= CP_W'(cp_cnt + 1'b1); // R20
    end
  end

  // gain: multiplier times 2^(shift+6)
  wire signed [ERR_W-1:0] cp_prod = cp_res * $signed({1'b0, cmul});
  wire signed [ERR_W-1:0] cp_err = cp_prod <<< ({2'h0, csh} + CP_GAIN_SH); // R21

  // phase error sample, one per divided reference period
  logic signed [ERR_W-1:0] err_lat;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      err_lat <= '0;
      coarse_used <= 1'b0;
    end else if (PH_SAMPLE) begin
      err_lat <= PH_FINE_OVF ? cp_err : ERR_W'(PH_FINE); // R1 R22
      coarse_used <= PH_FINE_OVF;
    end
  end

  // ==========================================================
  // loop filter: w' = w - G*w + x, step = A*(x - B*w)
  logic signed [ERR_W-1:0] lf_w;
  logic signed [ACC_W-1:0] d1;
  logic signed [ACC_W-1:0] d1p;
  logic [79:0] i2;
  logic [ACC_W-1:0] hold_word;
  logic [ACC_W-1:0] ftw_eff;
  logic [ACC_W-1:0] acc;

  wire signed [ERR_W-1:0] bw = mag_scale(lf_w, b0, b1);
  wire signed [ERR_W-1:0] gw = mag_scale(lf_w, g0, g1);
  wire signed [ERR_W-1:0] lf_u = err_lat - bw; // R23
  wire signed [ERR_W-1:0] next_w = lf_w - gw + err_lat; // R23
  wire signed [79:0] au_raw = lf_u * $signed({1'b0, a0});
  wire signed [79:0] au = (au_raw <<< a1) >>> ({2'h0, a2} + 5'(ALPHA_SH)); // R24
  wire signed [ACC_W-1:0] lf_step = au[ACC_W-1:0];

  // interpolator: second integrator increment for a held input,
  // i2 tracks P^2 times the filter output
  wire signed [79:0] dd = 80'(d1) - 80'(d1p);
  wire signed [79:0] cci_inc = (80'(d1p) <<< pexp) + dd * $signed({1'b0, p_m}); // R4
  wire [79:0] i2s = i2 >> {pexp, 1'b0}; // R25
  wire [ACC_W-1:0] cci_ftw = i2s[ACC_W-1:0];

  // outside closed loop the state is preloaded from the running word,
  // so closing the loop starts without a frequency step
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      lf_w <= '0;
      d1 <= '0;
      d1p <= '0;
      i2 <= '0;
    end else if (mode != MD_LOOP) begin
      lf_w <= '0;
      d1 <= '0;
      d1p <= '0;
      i2 <= 80'(ftw_eff) << {pexp, 1'b0};
    end else begin
      i2 <= i2 + cci_inc; // R4
      if (tick) begin
        lf_w <= next_w; // R3
        d1 <= lf_step; // R3
        d1p <= d1;
      end
    end
  end

  // ==========================================================
  // mode control
  wire want_hold = ctl[CTL_HOLD] || (ctl[CTL_AUTO] && REF_LOST); // R16
  dfd_mode_t next_mode;
  // single tone only from the control bit, never from a fault
  assign next_mode = !ctl[CTL_CLOSE] ? MD_TONE : // R10 R13
                     (hold_ok && want_hold) ? MD_HOLD : MD_LOOP; // R15 R16

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      mode <= MD_TONE;
      hold_ok <= 1'b0;
      hold_word <= '0;
    end else begin
      mode <= next_mode;
      if (mode == MD_LOOP && tick) begin
        hold_ok <= 1'b1; // R15
        hold_word <= cci_ftw; // R15
      end
    end
  end

  assign MODE = mode;
  assign HOLD_READY = hold_ok;

  // tuning word source; the tone word loses its lsb
  wire [ACC_W-1:0] tone_src = ctl[CTL_EST] ? EST_FTW : tone_ftw; // R11 R12
  always_comb begin
    case (mode)
      MD_LOOP: ftw_eff = cci_ftw; // R17
      MD_HOLD: ftw_eff = hold_word; // R15
      MD_TONE: ftw_eff = {tone_src[ACC_W-1:1], 1'b0}; // R14
      default: ftw_eff = '0;
    endcase
  end

  // ==========================================================
  // phase accumulator; f_out = word / 2^48 * f_clk
  wire [PH_W-1:0] acc_top = acc[ACC_W-1 -: PH_W];
  wire [PH_W-1:0] ph_ofs = ctl[CTL_EST] ? EST_PHASE : phofs; // R12
  wire [PH_W-1:0] ph_add = (mode == MD_LOOP) ? '0 : ph_ofs; // R18

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      acc <= '0;
      FTW_OUT <= '0;
      DDS_PHASE <= '0;
    end else begin
      acc <= acc + ftw_eff; // R7
      FTW_OUT <= ftw_eff; // R8
      DDS_PHASE <= acc_top + ph_add; // R9
    end
  end

  // ==========================================================
  // checks
  default clocking dfd_cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  sequence s_quiet;
    !tick [*8];
  endsequence
  sequence s_fsc_wr;
    REG_WR && (REG_ADDR == OFS_FSC_LO);
  endsequence

  property p_acc_wrap;
    $past(RST_B) |-> acc == ACC_W'($past(acc) + $past(ftw_eff));
  endproperty
  a_acc_wrap: assert property (p_acc_wrap) else $error("accumulator step wrong"); // R7

  property p_tone_lsb;
    (mode == MD_TONE) && !ctl[CTL_EST] |=> FTW_OUT == {$past(tone_ftw[ACC_W-1:1]), 1'b0};
  endproperty
  a_tone_lsb: assert property (p_tone_lsb) else $error("tone word not used"); // R14

  property p_loop_phase;
    mode == MD_LOOP |=> DDS_PHASE == $past(acc_top);
  endproperty
  a_loop_phase: assert property (p_loop_phase) else $error("offset active in loop"); // R18

  property p_open_phase;
    mode != MD_LOOP |=> DDS_PHASE == PH_W'($past(acc_top) + $past(ph_ofs));
  endproperty
  a_open_phase: assert property (p_open_phase) else $error("phase offset missing"); // R9

  property p_tick_gap;
    tick |=> s_quiet;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("divider period too short"); // R2

  property p_pick;
    PH_SAMPLE |=> err_lat == ($past(PH_FINE_OVF) ? $past(cp_err) : ERR_W'($past(PH_FINE)));
  endproperty
  a_pick: assert property (p_pick) else $error("wrong detector chosen"); // R22

  property p_hold_word;
    mode == MD_HOLD |-> hold_ok && (FTW_OUT == hold_word || $past(mode) != MD_HOLD);
  endproperty
  a_hold_word: assert property (p_hold_word) else $error("holdover word wrong"); // R15

  property p_open_tone;
    !ctl[CTL_CLOSE] |=> mode == MD_TONE;
  endproperty
  a_open_tone: assert property (p_open_tone) else $error("open loop not tone"); // R10

  property p_fsc;
    s_fsc_wr |=> DAC_FSC[7:0] == $past(REG_WDATA);
  endproperty
  a_fsc: assert property (p_fsc) else $error("scale code not taken"); // R19

  property p_coarse_cnt;
    cp_run && !cp_stop && (cp_cnt < CP_W'(CP_SPAN_CYC)) |=> cp_cnt == CP_W'($past(cp_cnt) + 1'b1);
  endproperty
  a_coarse_cnt: assert property (p_coarse_cnt) else $error("coarse count stalled"); // R20

endmodule

/* dfd_ref_model.sv */
`timescale 1ns/1ps
// ==========================================================
// reference and feedback source facing the phase detector
module dfd_ref_model #(
  parameter int PERIOD = 40
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // bench control
  input wire logic run,
  input wire logic ovf_mode,
  input wire logic [7:0] fb_lag,
  input wire logic signed [23:0] fine_val,
  // detector front end
  output logic ref_edge,
  output logic fb_edge,
  output logic ph_sample,
  output logic ph_fine_ovf,
  output logic signed [23:0] ph_fine
);
  logic [7:0] cnt;
  logic live;
  // a lost reference stops every edge; fb_lag must stay below PERIOD-2
  assign live = run && rst_b;
  // one divided reference period per PERIOD clocks
  always_ff @(posedge clk_sys) begin
    cnt <= (!live || cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
    ref_edge <= live && cnt == 8'h00;
    fb_edge <= live && cnt == fb_lag;
    ph_sample <= live && cnt == fb_lag + 8'h02;
    // outside the sample the lines show the inverse, so stale data cannot pass
    ph_fine <= (live && cnt == fb_lag + 8'h02) ? fine_val : ~fine_val;
    ph_fine_ovf <= (live && cnt == fb_lag + 8'h02) ? ovf_mode : !ovf_mode;
  end
endmodule

/* dfd_core_test.sv */
`timescale 1ns/1ps
module dfd_core_test import dfd_pkg::*;;
  // ==========================================================
  // stimulus and observed signals
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ref_lost = 1'b0;
  logic [47:0] est_ftw = 48'h000000000000;
  logic [13:0] est_phase = 14'h0000;
  logic run = 1'b0;
  logic ovf_mode = 1'b0;
  logic [7:0] reg_rdata;
  logic ref_edge;
  logic fb_edge;
  logic ph_sample;
  logic ph_fine_ovf;
  logic signed [23:0] ph_fine;
  logic [13:0] dds_phase;
  logic [47:0] ftw_out;
  logic [9:0] dac_fsc;
  logic [1:0] mode;
  logic hold_ready;
  logic [7:0] rv;
  logic [13:0] p0;
  logic [47:0] f0;
  int bad_count = 0;
  int n_tests = 0;
  // free-running sample clock
  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  // ==========================================================
  // instances; a short coarse span keeps saturation reachable
  dfd_ref_model #(.PERIOD(40)) ref_src (.clk_sys(clk_sys), .rst_b(rst_b),
    .run(run && !ref_lost), .ovf_mode(ovf_mode), .fb_lag(8'h05),
    .fine_val(24'sh0003E8), .ref_edge(ref_edge), .fb_edge(fb_edge),
    .ph_sample(ph_sample), .ph_fine_ovf(ph_fine_ovf), .ph_fine(ph_fine));
  dfd_core #(.FINE_W(24), .CP_SPAN_CYC(64)) uut (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .PH_SAMPLE(ph_sample), .PH_FINE(ph_fine),
    .PH_FINE_OVF(ph_fine_ovf), .REF_EDGE(ref_edge), .FB_EDGE(fb_edge),
    .REF_LOST(ref_lost), .EST_FTW(est_ftw), .EST_PHASE(est_phase),
    .DDS_PHASE(dds_phase), .FTW_OUT(ftw_out), .DAC_FSC(dac_fsc), .MODE(mode),
    .HOLD_READY(hold_ready));
  // ==========================================================
  // shared bus and check tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    rd(a, rv);
    chk(nm, e, rv);
  endtask
  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 8 && mode !== m; i++) cyc(1);
    chk("MODE", m, mode);
  endtask
  task automatic wr_tone(input logic [47:0] w);
    for (int i = 0; i < 6; i++) wr(OFS_CFG + 12'(CI_SINGLE_TONE_TUNING_WORD + i), w[8*i +: 8]);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdchk("control", OFS_CTL, CTL_RST);
    rdchk("scale low", OFS_FSC_LO, FSC_RST[7:0]);
    rdchk("scale high", OFS_FSC_HI, 8'h01);
    rdchk("rate exponent", OFS_CFG + 12'(CI_PEXP), 8'h05);
    chk("DAC_FSC", FSC_RST, dac_fsc);
    chk("MODE", MD_TONE, mode);
    chk("FTW_OUT", 48'h0, ftw_out);
    chk("HOLD_READY", 1'b0, hold_ready);
    $display("reset test done");
  endtask
  task automatic t_regs;
    wr(OFS_FSC_LO, 8'h34);
    wr(OFS_FSC_HI, 8'hFE);
    cyc(1);
    chk("DAC_FSC", 10'h234, dac_fsc);
    rdchk("scale high", OFS_FSC_HI, 8'h02);
    cyc(1);
    chk("idle rdata", 8'h00, reg_rdata);
    wr(OFS_STAT, 8'hFF);
    rdchk("status", OFS_STAT, 8'h00);
    rdchk("unmapped", 12'h300, 8'h00);
    $display("register test done");
  endtask
  // tone mode runs while the reference keeps toggling, which it must ignore
  task automatic t_tone;
    @(posedge clk_sys);
    run <= 1'b1;
    wr_tone(48'h000400000001);
    cyc(4);
    chk("FTW_OUT", 48'h000400000000, ftw_out);
    p0 = dds_phase;
    cyc(16);
    chk("phase step", 14'd16, 14'(dds_phase - p0));
    wr_tone(48'h0);
    cyc(4);
    p0 = dds_phase;
    wr(OFS_CFG + 12'(CI_PHOFS), 8'h00);
    wr(OFS_CFG + 12'(CI_PHOFS + 1), 8'h10);
    cyc(4);
    chk("phase offset", 14'(p0 + 14'h1000), dds_phase);
    $display("tone test done");
  endtask
  task automatic t_est;
    @(posedge clk_sys);
    est_ftw <= 48'h000000000001;
    est_phase <= 14'h0123;
    wr(OFS_CTL, 8'h02);
    cyc(4);
    chk("FTW_OUT", 48'h0, ftw_out);
    chk("est phase", 14'(p0 + 14'h0123), dds_phase);
    @(posedge clk_sys);
    est_ftw <= 48'h000800000003;
    cyc(4);
    chk("FTW_OUT", 48'h000800000002, ftw_out);
    wr(OFS_CTL, 8'h00);
    $display("estimator test done");
  endtask
  // forced holdover is asked for before the loop has ever run
  task automatic t_close;
    logic early;
    early = 1'b0;
    wr_tone(48'h0);
    wr(OFS_CFG + 12'(CI_PEXP), 8'h05);
    wr(OFS_CFG + 12'(CI_A0 + 1), 8'h08);
    wr(OFS_CFG + 12'(CI_A1), 8'h08);
    wr(OFS_CTL, 8'h09);
    for (int i = 0; i < 48 && hold_ready !== 1'b1; i++) begin
      cyc(1);
      if (mode === MD_HOLD && hold_ready !== 1'b1) early = 1'b1;
    end
    chk("early holdover", 1'b0, early);
    chk("HOLD_READY", 1'b1, hold_ready);
    wait_mode(MD_HOLD);
    $display("close test done");
  endtask
  task automatic t_loop;
    wr(OFS_CTL, 8'h01);
    wait_mode(MD_LOOP);
    cyc(200);
    f0 = ftw_out;
    cyc(200);
    n_tests++;
    if (ftw_out === f0) begin
      bad_count++;
      $display("Error FTW_OUT expected change seen %h", ftw_out);
    end
    @(posedge clk_sys);
    ovf_mode <= 1'b1;
    cyc(90);
    rdchk("status", OFS_STAT, 8'h05);
    @(posedge clk_sys);
    ovf_mode <= 1'b0;
    cyc(90);
    rdchk("status", OFS_STAT, 8'h01);
    $display("loop test done");
  endtask
  task automatic t_hold;
    wr(OFS_CTL, 8'h05);
    @(posedge clk_sys);
    ref_lost <= 1'b1;
    wait_mode(MD_HOLD);
    rdchk("status", OFS_STAT, 8'h03);
    cyc(70);
    f0 = ftw_out;
    cyc(100);
    chk("held word", f0, ftw_out);
    @(posedge clk_sys);
    ref_lost <= 1'b0;
    wait_mode(MD_LOOP);
    wr(OFS_CTL, 8'h00);
    wait_mode(MD_TONE);
    $display("holdover test done");
  endtask
  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc(1);
    t_reset();
    t_regs();
    t_tone();
    t_est();
    t_close();
    t_loop();
    t_hold();
    print_verdict();
  end
  // the scenarios need some 1000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
endmodule
